//--- logic/cms_pkg.sv
// constants, types and decode helpers for the counter mode sequencer
package cms_pkg;

    // ----------------------------------------------------------------
    // widths and types
    // ----------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;

    typedef logic [DATA_W-1:0] cms_word_t;
    typedef logic [ADDR_W-1:0] cms_addr_t;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam cms_addr_t REG_MODE   = 3'h0;
    localparam cms_addr_t REG_LOAD   = 3'h1;
    localparam cms_addr_t REG_HOLD   = 3'h2;
    localparam cms_addr_t REG_CMD    = 3'h3;
    localparam cms_addr_t REG_STATUS = 3'h4;
    localparam cms_addr_t REG_COUNT  = 3'h5;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam cms_word_t MODE_RST  = 16'h0000;
    localparam cms_word_t LOAD_RST  = 16'h0000;
    localparam cms_word_t HOLD_RST  = 16'h0000;
    localparam cms_word_t COUNT_RST = 16'h0000;
    localparam cms_word_t COUNT_ONE = 16'h0001;
    localparam cms_word_t READ_IDLE = 16'h0000;

    // ----------------------------------------------------------------
    // mode register fields
    // ----------------------------------------------------------------
    localparam int MODE_GATE_LSB   = 13;
    localparam int MODE_RR_LSB     = 5;
    localparam int MODE_TOGGLE_BIT = 4;
    localparam int SEL_W           = 3;

    // gating_select_bits layout
    localparam int GSEL_GATED_BIT = 2;
    localparam int GSEL_EDGE_BIT  = 1;
    localparam int GSEL_LOW_BIT   = 0;

    // reload_repeat_select_bits layout
    localparam int RR_REPEAT_BIT = 0;
    localparam int RR_ALT_BIT    = 1;

    // ----------------------------------------------------------------
    // command and status bits
    // ----------------------------------------------------------------
    localparam int CMD_ARM_BIT    = 0;
    localparam int CMD_DISARM_BIT = 1;
    localparam int CMD_LOAD_BIT   = 2;

    localparam int ST_ARMED_BIT    = 0;
    localparam int ST_TRIG_BIT     = 1;
    localparam int ST_TC_BIT       = 2;
    localparam int ST_OUT_BIT      = 3;
    localparam int ST_USE_HOLD_BIT = 4;

    // ----------------------------------------------------------------
    // gating decode
    // ----------------------------------------------------------------
    function automatic logic gate_is_level(input logic [SEL_W-1:0] gsel);
        gate_is_level = gsel[GSEL_GATED_BIT] & ~gsel[GSEL_EDGE_BIT];
    endfunction : gate_is_level

    function automatic logic gate_is_edge(input logic [SEL_W-1:0] gsel);
        gate_is_edge = gsel[GSEL_GATED_BIT] & gsel[GSEL_EDGE_BIT];
    endfunction : gate_is_edge

endpackage : cms_pkg

//--- logic/cms_edge_if.sv
// edge and level events passed from the input conditioner to the sequencer
`timescale 1ns/10ps
interface cms_edge_if;
    logic src_edge;
    logic gate_edge;
    logic gate_level;

    modport cond (output src_edge, output gate_edge, output gate_level);
    modport seq  (input src_edge, input gate_edge, input gate_level);
endinterface : cms_edge_if

//--- logic/cms_edge_cond.sv
// source and gate conditioner: active-going edge pulses and gate level
`timescale 1ns/10ps
module cms_edge_cond
    import cms_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic source,
    input  wire logic gate,
    input  wire logic gate_active_low,
    cms_edge_if.cond  ev
);
    logic src_prev_q;
    logic gate_prev_q;
    logic gate_lvl;

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    // a polarity change can fake one gate edge; software should reprogram while disarmed
    assign gate_lvl = gate ^ gate_active_low;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            src_prev_q  <= 1'b1;
            gate_prev_q <= 1'b1;
        end else begin
            src_prev_q  <= source;
            gate_prev_q <= gate_lvl;
        end
    end

    // inactive-going transitions never produce an event
    assign ev.src_edge   = source & ~src_prev_q;    // [R22]
    assign ev.gate_edge  = gate_lvl & ~gate_prev_q; // [R22]
    assign ev.gate_level = gate_lvl;

endmodule : cms_edge_cond

//--- logic/cms_seq.sv
// counter mode sequencer: arming, gating, terminal count and reload selection
//
// Functional notes
// [R1]: edge-triggered strobe ignores gate edges while the counter is disarmed.
// [R2]: after the trigger edge, counting starts on the next source edge until terminal count.
// [R3]: strobe reloads from load and disarms at terminal count; restart needs arm then edge.
// [R4]: once triggered, the gate is ignored for the rest of the cycle.
// [R5]: ungated rate generator ignores gate, repeats, reloads from load each terminal count.
// [R6]: toggle option makes rate generator output a square wave.
// [R7]: level-gated rate generator counts only source edges while gate is active.
// [R8]: one-shot: gate edge on armed counter starts; reload from load and stop at terminal count.
// [R9]: one-shot stays armed after terminal count; gate ignored until then.
// [R10]: software delayed pulse: gate ignored, hold reload first, then load and disarm.
// [R11]: software should preload the counter from load before a delayed pulse cycle.
// [R12]: toggled delayed pulse: initial count sets delay, hold sets pulse width.
// [R13]: gated delayed pulse counts only while gate is active.
// [R14]: hardware delayed pulse starts after gate edge, runs hold-then-load, then disarms.
// [R15]: software must arm before applying the hardware trigger edge.
// [R16]: ungated variable duty runs until disarm, alternating hold and load reloads.
// [R17]: toggled variable duty output: load and hold set the two output portions.
// [R18]: level-gated variable duty counts with gate active; alternation restarts at arm.
// [R19]: mode comes from gating select bits and reload/repeat select bits.
// [R20]: repeat bit clear disarms at cycle end; set keeps counting without re-arm.
// [R21]: a counter at terminal count always counts the next source edge.
// [R22]: only active-going source and gate transitions count as edges.
// [R23]: hardware delayed pulse ignores the gate until the second terminal count.
// [R24]: track next reload source per counter; arming selects hold.
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module cms_seq
    import cms_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      nrst,
    input  wire cms_addr_t addr,
    input  wire cms_word_t wdata,
    input  wire logic      wr,
    input  wire logic      rd,
    output cms_word_t      rdata,
    input  wire logic      source,
    input  wire logic      gate,
    output logic           counter_out,
    output logic           terminal_count,
    output logic           armed
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cms_word_t mode_q;
    cms_word_t load_q;
    cms_word_t hold_q;
    cms_word_t cnt_q;
    cms_word_t cnt_d;
    cms_word_t rdata_q;
    cms_word_t reload_val;
    cms_word_t status_w;
    logic      armed_q;
    logic      trig_q;
    logic      tc_q;
    logic      tc_d;
    logic      out_q;
    logic      use_hold_q;

    logic [SEL_W-1:0] gating_select_bits;
    logic [SEL_W-1:0] reload_repeat_select_bits;
    logic             toggle_on_terminal_count;
    logic             repeat_bit;
    logic             alt_en;
    logic             edge_mode;
    logic             level_mode;

    logic cmd_wr;
    logic arm_cmd;
    logic disarm_cmd;
    logic load_cmd;
    logic trigger;
    logic count_en;
    logic enter_tc;
    logic leave_tc;
    logic dec_edge;
    logic reload_hold;
    logic cycle_end;

    cms_edge_if ev ();

    cms_edge_cond u_cond (
        .clk             (clk),
        .nrst            (nrst),
        .source          (source),
        .gate            (gate),
        .gate_active_low (gating_select_bits[GSEL_LOW_BIT]),
        .ev              (ev.cond)
    );

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    assign gating_select_bits        = mode_q[MODE_GATE_LSB +: SEL_W]; // [R19]
    assign reload_repeat_select_bits = mode_q[MODE_RR_LSB +: SEL_W];   // [R19]
    assign toggle_on_terminal_count  = mode_q[MODE_TOGGLE_BIT];
    assign repeat_bit                = reload_repeat_select_bits[RR_REPEAT_BIT];
    assign alt_en                    = reload_repeat_select_bits[RR_ALT_BIT];
    assign edge_mode                 = gate_is_edge(gating_select_bits);
    assign level_mode                = gate_is_level(gating_select_bits);

    // ----------------------------------------------------------------
    // commands
    // ----------------------------------------------------------------
    assign cmd_wr     = wr && (addr == REG_CMD);
    assign arm_cmd    = cmd_wr & wdata[CMD_ARM_BIT];
    assign disarm_cmd = cmd_wr & wdata[CMD_DISARM_BIT];
    assign load_cmd   = cmd_wr & wdata[CMD_LOAD_BIT];

    // ----------------------------------------------------------------
    // count qualification
    // ----------------------------------------------------------------
    // a trigger needs an armed, idle counter; later edges fall through untouched
    assign trigger = ev.gate_edge & armed_q & edge_mode & ~trig_q & ~tc_q; // [R1] [R4] [R23]

    always_comb begin
        if (level_mode) begin
            count_en = armed_q & ev.gate_level;      // [R7] [R13] [R18]
        end else if (edge_mode) begin
            count_en = armed_q & trig_q;             // [R2] [R8] [R14]
        end else begin
            count_en = armed_q;                      // [R5] [R10] [R16]
        end
    end

    // at terminal count the next source edge always counts, armed or not
    assign leave_tc = ev.src_edge & tc_q;                                  // [R21]
    assign dec_edge = ev.src_edge & ~tc_q & count_en;
    assign enter_tc = dec_edge & (cnt_q == COUNT_ONE);

    assign reload_hold = alt_en & use_hold_q;                              // [R10] [R16]
    assign reload_val  = reload_hold ? hold_q : load_q;                    // [R12] [R17]
    // a cycle ends on every load reload; hold reloads are mid-cycle
    assign cycle_end   = leave_tc & ~reload_hold;

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // counting wins over a load command landing in the same cycle
    always_comb begin
        if (leave_tc) begin
            cnt_d = reload_val;                        // [R3] [R5] [R8] [R10]
        end else if (dec_edge) begin
            cnt_d = cnt_q - COUNT_ONE;
        end else if (load_cmd) begin
            cnt_d = load_q;                            // [R11]
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= COUNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // terminal count and output
    // ----------------------------------------------------------------
    assign tc_d = enter_tc | (tc_q & ~leave_tc);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tc_q <= 1'b0;
        end else begin
            tc_q <= tc_d;
        end
    end

    // toggled output flips on entry to terminal count
    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_q <= 1'b0;
        end else if (toggle_on_terminal_count) begin
            out_q <= out_q ^ enter_tc;                 // [R6] [R12] [R17]
        end else begin
            out_q <= tc_d;
        end
    end

    // ----------------------------------------------------------------
    // arming
    // ----------------------------------------------------------------
    // arm wins over an automatic disarm in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            armed_q <= 1'b0;
        end else if (arm_cmd) begin
            armed_q <= 1'b1;                           // [R3] [R15]
        end else if (disarm_cmd) begin
            armed_q <= 1'b0;                           // [R16]
        end else if (cycle_end && !repeat_bit) begin
            armed_q <= 1'b0;                           // [R3] [R10] [R14] [R20]
        end
    end

    // trigger latch: ends with the cycle; one-shot repeat stays armed
    always_ff @(posedge clk) begin
        if (!nrst) begin
            trig_q <= 1'b0;
        end else if (arm_cmd || disarm_cmd) begin
            trig_q <= 1'b0;
        end else if (trigger) begin
            trig_q <= 1'b1;                            // [R2] [R14]
        end else if (cycle_end) begin
            trig_q <= 1'b0;                            // [R8] [R9] [R23]
        end
    end

    // ----------------------------------------------------------------
    // reload source selection
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            use_hold_q <= 1'b1;
        end else if (arm_cmd) begin
            use_hold_q <= 1'b1;                        // [R18] [R24]
        end else if (leave_tc && alt_en) begin
            use_hold_q <= ~use_hold_q;                 // [R16] [R24]
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_q <= MODE_RST;
            load_q <= LOAD_RST;
            hold_q <= HOLD_RST;
        end else if (wr) begin
            if (addr == REG_MODE) begin
                mode_q <= wdata;
            end
            if (addr == REG_LOAD) begin
                load_q <= wdata;
            end
            if (addr == REG_HOLD) begin
                hold_q <= wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    always_comb begin
        status_w                  = READ_IDLE;
        status_w[ST_ARMED_BIT]    = armed_q;
        status_w[ST_TRIG_BIT]     = trig_q;
        status_w[ST_TC_BIT]       = tc_q;
        status_w[ST_OUT_BIT]      = out_q;
        status_w[ST_USE_HOLD_BIT] = use_hold_q;
    end

    // unmapped offsets and idle cycles read as zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_q <= READ_IDLE;
        end else if (rd) begin
            unique case (addr)
                REG_MODE:   rdata_q <= mode_q;
                REG_LOAD:   rdata_q <= load_q;
                REG_HOLD:   rdata_q <= hold_q;
                REG_STATUS: rdata_q <= status_w;
                REG_COUNT:  rdata_q <= cnt_q;
                default:    rdata_q <= READ_IDLE;
            endcase
        end else begin
            rdata_q <= READ_IDLE;
        end
    end

    assign rdata          = rdata_q;
    assign counter_out    = out_q;
    assign terminal_count = tc_q;
    assign armed          = armed_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_disarmed_gate_ignored: assert property ( // [R1]
        @(posedge clk) disable iff (!nrst)
        (!armed_q && !arm_cmd && ev.gate_edge) |=> !trig_q
    ) else $error("gate edge triggered a disarmed counter");

    a_trig_then_count: assert property ( // [R2]
        @(posedge clk) disable iff (!nrst)
        (trigger && !arm_cmd && !disarm_cmd) ##1
        (ev.src_edge && cnt_q != COUNT_ONE && armed_q)
        |=> (cnt_q == $past(cnt_q) - COUNT_ONE)
    ) else $error("first source edge after trigger not counted");

    a_strobe_end_disarm: assert property ( // [R3]
        @(posedge clk) disable iff (!nrst)
        (leave_tc && edge_mode && !repeat_bit && !alt_en && !arm_cmd)
        |=> (!armed_q && !trig_q && cnt_q == $past(load_q))
    ) else $error("strobe did not reload and disarm");

    a_trig_gate_hold: assert property ( // [R4]
        @(posedge clk) disable iff (!nrst)
        (trig_q && ev.gate_edge && !leave_tc && !arm_cmd && !disarm_cmd)
        |=> trig_q
    ) else $error("gate edge disturbed a running cycle");

    a_ungated_counts: assert property ( // [R5]
        @(posedge clk) disable iff (!nrst)
        (gating_select_bits == 3'h0 && armed_q && ev.src_edge && !tc_q && cnt_q != COUNT_ONE)
        |=> (cnt_q == $past(cnt_q) - COUNT_ONE)
    ) else $error("ungated counter missed a source edge");

    a_toggle_flip: assert property ( // [R6]
        @(posedge clk) disable iff (!nrst)
        (toggle_on_terminal_count && enter_tc) |=> (out_q != $past(out_q))
    ) else $error("toggled output did not flip at terminal count");

    a_level_gate_stall: assert property ( // [R7]
        @(posedge clk) disable iff (!nrst)
        (level_mode && !ev.gate_level && ev.src_edge && !tc_q && !load_cmd)
        |=> (cnt_q == $past(cnt_q))
    ) else $error("level-gated counter counted with gate inactive");

    a_oneshot_rearm: assert property ( // [R9]
        @(posedge clk) disable iff (!nrst)
        (leave_tc && edge_mode && repeat_bit && !alt_en && armed_q && !arm_cmd && !disarm_cmd)
        |=> (armed_q && !trig_q)
    ) else $error("one-shot did not stay armed and wait");

    a_hold_reload: assert property ( // [R10]
        @(posedge clk) disable iff (!nrst)
        (leave_tc && alt_en && use_hold_q && !arm_cmd)
        |=> (cnt_q == $past(hold_q) && !use_hold_q)
    ) else $error("first terminal count did not reload from hold");

    a_duty_runs_on: assert property ( // [R16]
        @(posedge clk) disable iff (!nrst)
        (leave_tc && alt_en && repeat_bit && armed_q && !disarm_cmd && !arm_cmd)
        |=> armed_q ##0 (use_hold_q != $past(use_hold_q))
    ) else $error("variable duty cycle stopped or did not alternate");

    a_tc_always_left: assert property ( // [R21]
        @(posedge clk) disable iff (!nrst)
        (tc_q && ev.src_edge) |=> !tc_q
    ) else $error("terminal count not left on source edge");

    a_arm_selects_hold: assert property ( // [R24]
        @(posedge clk) disable iff (!nrst)
        arm_cmd |=> (use_hold_q && armed_q)
    ) else $error("arm did not restart reload alternation");

endmodule : cms_seq

//--- verification/cms_ext_model.sv
// far side model: source pulse train and gate level driven on clock edges
`timescale 1ns/10ps
module cms_ext_model (
    input  wire logic clk,
    output logic      source,
    output logic      gate
);
    initial begin
        source = 1'b0;
        gate   = 1'b0;
    end

    // two low samples between pulses so every rise is a fresh edge
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk) source <= 1'b1;
            @(posedge clk) source <= 1'b0;
            @(posedge clk);
        end
    endtask : pulse

    // caller raises the trigger after the arm command lands, except in the dropped-edge check that raises it before arm
    task automatic set_gate(input logic v);
        @(posedge clk) gate <= v;
        @(posedge clk);
    endtask : set_gate
endmodule : cms_ext_model

//--- verification/tb_counter_mode_sequencer_c_to_k.sv
// self-checking bench for the counter mode sequencer
`timescale 1ns/10ps
module tb_counter_mode_sequencer_c_to_k;
    import cms_pkg::*;

    logic      clk;
    logic      nrst;
    cms_addr_t addr;
    cms_word_t wdata;
    logic      wr;
    logic      rd;
    cms_word_t rdata;
    logic      source;
    logic      gate;
    logic      counter_out;
    logic      terminal_count;
    logic      armed;
    int        n_mismatch;
    int        checked;
    cms_word_t d;

    typedef struct {
        cms_word_t mode;
        logic      gate_hi;
        int        npulse;
        cms_word_t cnt;
        logic      arm;
    } cms_row_t;

    // load 3, hold 2 for every row
    cms_row_t rows [12] = '{
        '{16'hC000, 1'b1, 4, 16'h0003, 1'b0},  // strobe reloads and disarms
        '{16'hC000, 1'b0, 2, 16'h0003, 1'b1},  // no trigger, no count
        '{16'h0020, 1'b0, 6, 16'h0001, 1'b1},  // repeats from load
        '{16'h8020, 1'b0, 2, 16'h0003, 1'b1},  // gate inactive blocks
        '{16'h8020, 1'b1, 2, 16'h0001, 1'b1},  // gate active counts
        '{16'hC020, 1'b1, 6, 16'h0003, 1'b1},  // one-shot stops, stays armed
        '{16'h0040, 1'b0, 4, 16'h0002, 1'b1},  // first reload from hold
        '{16'h0040, 1'b0, 7, 16'h0003, 1'b0},  // second from load, disarm
        '{16'h8040, 1'b1, 7, 16'h0003, 1'b0},  // gated delayed pulse
        '{16'hC040, 1'b1, 7, 16'h0003, 1'b0},  // triggered delayed pulse
        '{16'h8060, 1'b1, 4, 16'h0002, 1'b1},  // alternation starts with hold
        '{16'hA020, 1'b0, 2, 16'h0001, 1'b1}   // active-low gate counts while pin low
    };

    cms_seq uut (
        .clk            (clk),
        .nrst           (nrst),
        .addr           (addr),
        .wdata          (wdata),
        .wr             (wr),
        .rd             (rd),
        .rdata          (rdata),
        .source         (source),
        .gate           (gate),
        .counter_out    (counter_out),
        .terminal_count (terminal_count),
        .armed          (armed)
    );

    cms_ext_model ext (
        .clk    (clk),
        .source (source),
        .gate   (gate)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic wr_reg(input cms_addr_t a, input cms_word_t v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input cms_addr_t a, output cms_word_t v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    task automatic chk(input cms_word_t got, input cms_word_t exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic setup(input cms_word_t mode, input cms_word_t load);
        wr_reg(REG_MODE, mode);
        wr_reg(REG_LOAD, load);
        wr_reg(REG_HOLD, 16'h0002);
        wr_reg(REG_CMD, 16'h0006);  // disarm and preload from load
    endtask : setup

    task automatic report_and_stop;
        $display("mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        nrst  = 1'b0;
        addr  = 3'h0;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
        n_mismatch = 0;
        checked    = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(REG_MODE, d);
        chk(d, MODE_RST);
        rd_reg(REG_STATUS, d);
        chk(d, 16'h0010);  // reload select starts at hold
        rd_reg(3'h6, d);
        chk(d, READ_IDLE);
        @(posedge clk) #1 chk(rdata, READ_IDLE);

        foreach (rows[i]) begin
            ext.set_gate(1'b0);
            setup(rows[i].mode, 16'h0003);
            wr_reg(REG_CMD, 16'h0001);
            if (rows[i].gate_hi)
                ext.set_gate(1'b1);
            ext.pulse(rows[i].npulse);
            rd_reg(REG_COUNT, d);
            chk(d, rows[i].cnt);
            chk({15'h0000, armed}, {15'h0000, rows[i].arm});
        end

        // gate edge before arm is dropped, then gate ignored after trigger
        ext.set_gate(1'b0);
        setup(16'hC000, 16'h0003);
        ext.set_gate(1'b1);
        wr_reg(REG_CMD, 16'h0001);
        ext.pulse(2);
        rd_reg(REG_COUNT, d);
        chk(d, 16'h0003);
        ext.set_gate(1'b0);
        ext.set_gate(1'b1);
        ext.pulse(1);
        ext.set_gate(1'b0);
        ext.set_gate(1'b1);  // second edge mid-cycle must not restart
        ext.pulse(1);
        rd_reg(REG_COUNT, d);
        chk(d, 16'h0001);

        // counter at terminal count counts even with gate inactive
        setup(16'h8020, 16'h0003);
        wr_reg(REG_CMD, 16'h0001);
        ext.set_gate(1'b1);
        ext.pulse(3);
        chk({15'h0000, terminal_count}, 16'h0001);
        ext.set_gate(1'b0);
        ext.pulse(1);
        rd_reg(REG_COUNT, d);
        chk(d, 16'h0003);

        // toggled output flips at each terminal count
        setup(16'h0030, 16'h0002);
        wr_reg(REG_CMD, 16'h0001);
        rd_reg(REG_STATUS, d);
        d = {15'h0000, ~d[ST_OUT_BIT]};
        ext.pulse(2);
        chk({15'h0000, counter_out}, d);
        ext.pulse(3);
        chk({15'h0000, counter_out}, {15'h0000, ~d[0]});

        // variable duty runs until disarm
        setup(16'h0060, 16'h0003);
        wr_reg(REG_CMD, 16'h0001);
        ext.pulse(8);
        rd_reg(REG_COUNT, d);
        chk(d, 16'h0002);
        wr_reg(REG_CMD, 16'h0002);
        ext.pulse(2);
        rd_reg(REG_COUNT, d);
        chk(d, 16'h0002);
        report_and_stop();
    end
endmodule : tb_counter_mode_sequencer_c_to_k
